// ### rtl/cen_consts.vh
// Constants of the camera event notifier: event kinds, identifiers, widths and timing.
// Assumes inclusion by bare name from the design files; definitions only.
`ifndef CEN_CONSTS_VH
`define CEN_CONSTS_VH

// ==========================================================================
// Event kinds, selector encoding and reset value
`define CEN_KIND_W 3
`define CEN_KIND_ACCEPTED 3'h0
`define CEN_KIND_REJECTED 3'h1
`define CEN_KIND_WAIT 3'h2
`define CEN_KIND_UPDATE 3'h3
`define CEN_KIND_SETTLED 3'h4
`define CEN_KIND_COUNT 5
`define CEN_SELECT_RST 3'h0
`define CEN_ENABLE_RST 5'h00

// ==========================================================================
// Event identifiers (values are arbitrary, only distinct)
`define CEN_ID_W 16
`define CEN_ID_BASE 16'h9000

// ==========================================================================
// Data widths
`define CEN_TS_W 64
`define CEN_VAL_W 32

// ==========================================================================
// Timing: notification delay in microseconds, clock in MHz
`define CEN_CLK_MHZ 20
`define CEN_NOTIFY_DELAY_US 4000
`define CEN_DELAY_CYCLES (`CEN_NOTIFY_DELAY_US * `CEN_CLK_MHZ)
`define CEN_DELAY_W 24

`endif

// ### rtl/cen_timestamp.v
// Free running timestamp counter with clear and latch commands.
// Assumes commands come from logic on the same clock.
`timescale 1ns/1ns
`default_nettype none
`include "cen_consts.vh"

module cen_timestamp
(
  // Clock and reset
  input wire i_clk,
  input wire i_rst,
  // Commands
  input wire i_clear,
  input wire i_latch,
  // Values
  output reg [`CEN_TS_W-1:0] o_count_q,
  output reg [`CEN_TS_W-1:0] o_latched_q
);

  // ==========================================================================
  // Counter
  // Clear wins over counting so the count starts again from zero.
  always @(posedge i_clk)
  begin
    if (i_rst || i_clear)
      o_count_q <= {`CEN_TS_W{1'b0}};
    else
      o_count_q <= o_count_q + {{(`CEN_TS_W-1){1'b0}}, 1'b1};
  end

  // Latch copy for readback.
  always @(posedge i_clk)
  begin
    if (i_rst)
      o_latched_q <= {`CEN_TS_W{1'b0}};
    else if (i_latch)
      o_latched_q <= o_count_q;
  end

endmodule
`default_nettype wire

// ### rtl/cen_notifier.v
// Event notifier: detects trigger and auto level events, stamps them and
// sends enabled ones to the host after a fixed delay.
// Assumes all event inputs are single-cycle pulses from logic on i_clk, except
// the external trigger pin, which is asynchronous and synchronised here.
`timescale 1ns/1ns
`default_nettype none
`include "cen_consts.vh"

// Overview of operation
// - Selector picks one kind; resets to accepted.
// - Accepted trigger raises accepted-trigger event.
// - Rejected trigger raises rejected-trigger event.
// - Entering trigger wait raises wait event.
// - Auto level update raises update event.
// - Auto level convergence raises settled event.
// - Per-kind writable enable, off after reset.
// - Each kind has a distinct readable identifier.
// - Every captured event (enabled, none in flight) records the current timestamp.
// - Auto level events capture luminance, exposure, gain.
// - Notification sent about 4 ms after event.
// - Timestamp counter clearable and latchable.
// - Trigger during wait pulses exposure start one clock after the accepted-trigger event.
module cen_notifier
#(
  parameter DELAY_CYCLES = `CEN_DELAY_CYCLES
)
(
  // Clock and reset
  input wire i_clk,
  input wire i_rst,
  // Configuration access
  input wire [`CEN_KIND_W-1:0] i_event_kind_select,
  input wire i_select_write,
  input wire i_event_notify_enable,
  input wire i_enable_write,
  // Timestamp commands
  input wire i_ts_clear,
  input wire i_ts_latch,
  // Trigger sources
  input wire i_ext_trigger,
  input wire i_soft_trigger,
  input wire i_arm,
  input wire i_exposure_done,
  // Auto level control
  input wire i_auto_level_update,
  input wire i_auto_level_settled,
  input wire [`CEN_VAL_W-1:0] i_total_lum,
  input wire [`CEN_VAL_W-1:0] i_avg_lum,
  input wire [`CEN_VAL_W-1:0] i_exposure_time,
  input wire [`CEN_VAL_W-1:0] i_gain,
  // Readback
  output reg [`CEN_KIND_W-1:0] o_event_kind_select,
  output reg o_event_notify_enable,
  output reg [`CEN_ID_W-1:0] o_event_id,
  output reg [`CEN_TS_W-1:0] o_ts_latched,
  output reg o_trigger_wait,
  output reg o_exposure_start,
  // Notification to host
  output reg o_notify_valid,
  output reg [`CEN_KIND_W-1:0] o_notify_kind,
  output reg [`CEN_ID_W-1:0] o_notify_id,
  output reg [`CEN_TS_W-1:0] o_notify_ts,
  output reg [`CEN_VAL_W-1:0] o_notify_total_lum,
  output reg [`CEN_VAL_W-1:0] o_notify_avg_lum,
  output reg [`CEN_VAL_W-1:0] o_notify_exposure,
  output reg [`CEN_VAL_W-1:0] o_notify_gain
);

  localparam integer DELAY_LAST_I = DELAY_CYCLES - 1;
  localparam [`CEN_DELAY_W-1:0] DELAY_LAST = DELAY_LAST_I[`CEN_DELAY_W-1:0];
  localparam [2:0] ST_IDLE = 3'h1;
  localparam [2:0] ST_WAIT = 3'h2;
  localparam [2:0] ST_EXPOSE = 3'h4;

  reg [`CEN_KIND_W-1:0] sel_q;
  reg [`CEN_KIND_COUNT-1:0] en_q;
  reg trig_s1_q;
  reg trig_s2_q;
  reg trig_s3_q;
  reg [2:0] state_q;
  reg [2:0] state_d;
  reg [`CEN_KIND_COUNT-1:0] ev;
  reg pend_q;
  reg [`CEN_DELAY_W-1:0] dly_q;
  reg [`CEN_KIND_W-1:0] p_kind_q;
  reg [`CEN_TS_W-1:0] p_ts_q;
  reg [`CEN_VAL_W-1:0] p_tl_q;
  reg [`CEN_VAL_W-1:0] p_al_q;
  reg [`CEN_VAL_W-1:0] p_ex_q;
  reg [`CEN_VAL_W-1:0] p_gn_q;
  reg [`CEN_KIND_W-1:0] cap_kind;
  reg cap_any;
  wire [`CEN_TS_W-1:0] ts_now;
  wire [`CEN_TS_W-1:0] ts_latched;
  wire trig_edge;
  integer k;

  // ==========================================================================
  // Timestamp source
  cen_timestamp u_ts
  (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_clear(i_ts_clear),
    .i_latch(i_ts_latch),
    .o_count_q(ts_now),
    .o_latched_q(ts_latched)
  );

  // ==========================================================================
  // Configuration
  // The enable is stored per kind; the write lands on the selected kind.
  always @(posedge i_clk)
  begin
    if (i_rst)
    begin
      sel_q <= `CEN_SELECT_RST;
      en_q <= `CEN_ENABLE_RST;
    end
    else
    begin
      if (i_select_write && i_event_kind_select < `CEN_KIND_COUNT)
        sel_q <= i_event_kind_select;
      if (i_enable_write)
        en_q[sel_q] <= i_event_notify_enable;
    end
  end

  // ==========================================================================
  // Trigger pin synchroniser; only the second and third stages are examined.
  always @(posedge i_clk)
  begin
    if (i_rst)
    begin
      trig_s1_q <= 1'b0;
      trig_s2_q <= 1'b0;
      trig_s3_q <= 1'b0;
    end
    else
    begin
      trig_s1_q <= i_ext_trigger;
      trig_s2_q <= trig_s1_q;
      trig_s3_q <= trig_s2_q;
    end
  end

  assign trig_edge = (trig_s2_q && !trig_s3_q) || i_soft_trigger;

  // ==========================================================================
  // Trigger sequencer and event detection
  // A trigger outside the wait state cannot start an exposure and is rejected.
  always @*
  begin
    state_d = state_q;
    ev = {`CEN_KIND_COUNT{1'b0}};
    case (state_q)
      ST_IDLE:
      begin
        if (trig_edge)
          ev[`CEN_KIND_REJECTED] = 1'b1;
        else if (i_arm)
        begin
          state_d = ST_WAIT;
          ev[`CEN_KIND_WAIT] = 1'b1;
        end
      end
      ST_WAIT:
      begin
        if (trig_edge)
        begin
          state_d = ST_EXPOSE;
          ev[`CEN_KIND_ACCEPTED] = 1'b1;
        end
      end
      ST_EXPOSE:
      begin
        if (trig_edge)
          ev[`CEN_KIND_REJECTED] = 1'b1;
        if (i_exposure_done)
          state_d = ST_IDLE;
      end
      default:
        state_d = ST_IDLE;
    endcase
    ev[`CEN_KIND_UPDATE] = i_auto_level_update;
    ev[`CEN_KIND_SETTLED] = i_auto_level_settled;
  end

  always @(posedge i_clk)
  begin
    if (i_rst)
      state_q <= ST_IDLE;
    else
      state_q <= state_d;
  end

  // ==========================================================================
  // Capture choice: lowest-numbered enabled event wins when several coincide.
  // Only one notification is in flight; events meanwhile are dropped, which
  // trades coverage of bursts for a bufferless design.
  always @*
  begin
    cap_any = 1'b0;
    cap_kind = {`CEN_KIND_W{1'b0}};
    for (k = `CEN_KIND_COUNT - 1; k >= 0; k = k - 1)
    begin
      if (ev[k] && en_q[k])
      begin
        cap_any = 1'b1;
        cap_kind = k[`CEN_KIND_W-1:0];
      end
    end
  end

  // ==========================================================================
  // Pending notification with its delay counter
  always @(posedge i_clk)
  begin
    if (i_rst)
    begin
      pend_q <= 1'b0;
      dly_q <= {`CEN_DELAY_W{1'b0}};
      p_kind_q <= {`CEN_KIND_W{1'b0}};
      p_ts_q <= {`CEN_TS_W{1'b0}};
      p_tl_q <= {`CEN_VAL_W{1'b0}};
      p_al_q <= {`CEN_VAL_W{1'b0}};
      p_ex_q <= {`CEN_VAL_W{1'b0}};
      p_gn_q <= {`CEN_VAL_W{1'b0}};
    end
    else if (!pend_q)
    begin
      if (cap_any)
      begin
        pend_q <= 1'b1;
        dly_q <= {`CEN_DELAY_W{1'b0}};
        p_kind_q <= cap_kind;
        p_ts_q <= ts_now;
        if (cap_kind == `CEN_KIND_UPDATE || cap_kind == `CEN_KIND_SETTLED)
        begin
          p_tl_q <= i_total_lum;
          p_al_q <= i_avg_lum;
          p_ex_q <= i_exposure_time;
          p_gn_q <= i_gain;
        end
        else
        begin
          p_tl_q <= {`CEN_VAL_W{1'b0}};
          p_al_q <= {`CEN_VAL_W{1'b0}};
          p_ex_q <= {`CEN_VAL_W{1'b0}};
          p_gn_q <= {`CEN_VAL_W{1'b0}};
        end
      end
    end
    else if (dly_q == DELAY_LAST)
      pend_q <= 1'b0;
    else
      dly_q <= dly_q + {{(`CEN_DELAY_W-1){1'b0}}, 1'b1};
  end

  // ==========================================================================
  // Registered outputs
  always @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_event_kind_select <= `CEN_SELECT_RST;
      o_event_notify_enable <= 1'b0;
      o_event_id <= `CEN_ID_BASE;
      o_ts_latched <= {`CEN_TS_W{1'b0}};
      o_trigger_wait <= 1'b0;
      o_exposure_start <= 1'b0;
      o_notify_valid <= 1'b0;
      o_notify_kind <= {`CEN_KIND_W{1'b0}};
      o_notify_id <= {`CEN_ID_W{1'b0}};
      o_notify_ts <= {`CEN_TS_W{1'b0}};
      o_notify_total_lum <= {`CEN_VAL_W{1'b0}};
      o_notify_avg_lum <= {`CEN_VAL_W{1'b0}};
      o_notify_exposure <= {`CEN_VAL_W{1'b0}};
      o_notify_gain <= {`CEN_VAL_W{1'b0}};
    end
    else
    begin
      o_event_kind_select <= sel_q;
      o_event_notify_enable <= en_q[sel_q];
      o_event_id <= `CEN_ID_BASE + {{(`CEN_ID_W-`CEN_KIND_W){1'b0}}, sel_q};
      o_ts_latched <= ts_latched;
      o_trigger_wait <= (state_q == ST_WAIT);
      o_exposure_start <= ev[`CEN_KIND_ACCEPTED];
      o_notify_valid <= pend_q && (dly_q == DELAY_LAST);
      if (pend_q && dly_q == DELAY_LAST)
      begin
        o_notify_kind <= p_kind_q;
        o_notify_id <= `CEN_ID_BASE + {{(`CEN_ID_W-`CEN_KIND_W){1'b0}}, p_kind_q};
        o_notify_ts <= p_ts_q;
        o_notify_total_lum <= p_tl_q;
        o_notify_avg_lum <= p_al_q;
        o_notify_exposure <= p_ex_q;
        o_notify_gain <= p_gn_q;
      end
    end
  end

endmodule
`default_nettype wire

// ### testbench/cen_host.sv
// Host-side receiver model for notifications from the event notifier.
// Assumes notifications arrive as one-cycle valid pulses on i_clk.
`timescale 1ns/1ns
`default_nettype none
module cen_host (
  // Clock and notification
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_valid,
  input wire logic [2:0] i_kind,
  // Received state
  output var logic [31:0] o_count,
  output var logic [2:0] o_kind
);
  // Takes each pulse in its one cycle; nothing else qualifies it.
  always @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_count <= 32'h0;
      o_kind <= 3'h0;
    end
    else if (i_valid === 1'b1)
    begin
      o_count <= o_count + 1;
      o_kind <= i_kind;
    end
  end
endmodule
`default_nettype wire

// ### testbench/cen_notifier_assertions.sv
// Concurrent checks on the notifier's ports.
// Assumes a bind onto cen_notifier with one clock domain.
`timescale 1ns/1ns
`default_nettype none
module cen_chk (
  // Clock, reset and inputs
  input wire i_clk,
  input wire i_rst,
  input wire [2:0] i_event_kind_select,
  input wire i_select_write,
  input wire i_arm,
  // Outputs watched
  input wire [2:0] o_event_kind_select,
  input wire o_event_notify_enable,
  input wire o_trigger_wait,
  input wire o_exposure_start,
  input wire o_notify_valid,
  input wire [2:0] o_notify_kind,
  input wire [15:0] o_notify_id,
  input wire [31:0] o_notify_gain
);
  // ==========================================================
  // Assertions
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  a_notify_pulse: assert property (o_notify_valid |=> !o_notify_valid)
    else $error("valid too long");
  // The readback sits one register behind the selector, so it follows two edges on.
  a_select_taken: assert property (i_select_write && i_event_kind_select < 3'h5
    |-> ##2 o_event_kind_select == $past(i_event_kind_select, 2)) else $error("select lost");
  a_select_refused: assert property (i_select_write && i_event_kind_select > 3'h4
    |-> ##2 $stable(o_event_kind_select)) else $error("bad select taken");
  a_id_kind: assert property (o_notify_valid |-> o_notify_id == 16'h9000 + o_notify_kind)
    else $error("id mismatch");
  a_kind_legal: assert property (o_notify_valid |-> o_notify_kind < 3'h5)
    else $error("kind illegal");
  a_trig_gain: assert property (o_notify_valid && o_notify_kind < 3'h3 |-> o_notify_gain == 0)
    else $error("gain on trigger");
  a_start_waited: assert property (o_exposure_start |-> o_trigger_wait ##1 !o_trigger_wait)
    else $error("start without wait");
  a_wait_armed: assert property ($rose(o_trigger_wait) |-> $past(i_arm, 2))
    else $error("wait without arm");
  // Reset is checked with the disable switched off on purpose.
  a_reset_clear: assert property (disable iff (1'b0) i_rst |=> !o_notify_valid
    && o_event_kind_select == 0 && !o_event_notify_enable) else $error("reset state");
  c_settled: cover property (o_notify_valid && o_notify_kind == 3'h4);
  c_start: cover property (o_exposure_start);
  c_wait: cover property ($rose(o_trigger_wait));
endmodule
bind cen_notifier cen_chk chk (.i_clk(i_clk), .i_rst(i_rst),
  .i_event_kind_select(i_event_kind_select), .i_select_write(i_select_write),
  .i_arm(i_arm), .o_event_kind_select(o_event_kind_select),
  .o_event_notify_enable(o_event_notify_enable), .o_trigger_wait(o_trigger_wait),
  .o_exposure_start(o_exposure_start), .o_notify_valid(o_notify_valid),
  .o_notify_kind(o_notify_kind), .o_notify_id(o_notify_id), .o_notify_gain(o_notify_gain));
`default_nettype wire

// ### testbench/tb.sv
// Self-checking bench of the notifier with random auto level values.
// Assumes cen_consts.vh on the include path and a short delay parameter.
`timescale 1ns/1ns
`default_nettype none
`include "cen_consts.vh"
module tb;
  localparam int D = 8;
  logic clk = 0, rst = 1, sw = 0, en = 0, ew = 0, tcl = 0, tlt = 0, ext = 0;
  logic sft = 0, arm = 0, done = 0, upd = 0, stl = 0;
  logic [2:0] sel = 0;
  logic [31:0] tl = 0, al = 0, ex = 0, gn = 0;
  wire [2:0] ks, nk, hk;
  wire ne, tw, xs, nv;
  wire [15:0] id, ni;
  wire [63:0] tsl, nts;
  wire [31:0] ntl, nal, nex, ngn, hc;
  int n_errors = 0, total_checks = 0, seed = 18369, cyc = 0, c0 = -1, n, k;
  logic [63:0] ts0, e1, e2;
  cen_notifier #(.DELAY_CYCLES(D)) uut (.i_clk(clk), .i_rst(rst),
    .i_event_kind_select(sel), .i_select_write(sw), .i_event_notify_enable(en),
    .i_enable_write(ew), .i_ts_clear(tcl), .i_ts_latch(tlt), .i_ext_trigger(ext),
    .i_soft_trigger(sft), .i_arm(arm), .i_exposure_done(done),
    .i_auto_level_update(upd), .i_auto_level_settled(stl), .i_total_lum(tl),
    .i_avg_lum(al), .i_exposure_time(ex), .i_gain(gn), .o_event_kind_select(ks),
    .o_event_notify_enable(ne), .o_event_id(id), .o_ts_latched(tsl),
    .o_trigger_wait(tw), .o_exposure_start(xs), .o_notify_valid(nv),
    .o_notify_kind(nk), .o_notify_id(ni), .o_notify_ts(nts), .o_notify_total_lum(ntl),
    .o_notify_avg_lum(nal), .o_notify_exposure(nex), .o_notify_gain(ngn));
  cen_host host (.i_clk(clk), .i_rst(rst), .i_valid(nv), .i_kind(nk), .o_count(hc),
    .o_kind(hk));
  // ==========================================================
  // Clock and cycle count; stamps are compared as differences, except the latched stamp bound checked after a clear.
  always #25 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  task chk(input logic [63:0] s, input logic [63:0] e);
    total_checks++;
    if (s !== e)
    begin
      n_errors++;
      $display("unexpected at %0t: %h not %h", $time, s, e);
    end
  endtask
  task results;
    if (n_errors == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Bounded wait for a notification; a lost one ends the run when must is set.
  task wv(input int m, input bit must);
    n = 0;
    while (nv !== 1'b1 && n < m)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    if (must && n == m)
    begin
      n_errors++;
      results;
    end
  endtask
  task cfg(input logic [2:0] k, input logic v, input logic w);
    @(posedge clk);
    sel <= k;
    sw <= 1;
    @(posedge clk);
    sw <= 0;
    en <= v;
    ew <= w;
    @(posedge clk);
    ew <= 0;
    @(posedge clk);
    #1;
    chk(ks, k);
    chk(ne, v);
    chk(id, `CEN_ID_BASE + k);
  endtask
  task fire(input int k, input bit on);
    int ce;
    @(posedge clk);
    {sft, arm, upd, stl} <= {k < 2, k == 2, k == 3, k == 4};
    {tl, al, ex, gn} <= {$random(seed), $random(seed), $random(seed), $random(seed)};
    @(posedge clk);
    {sft, arm, upd, stl} <= 0;
    ce = cyc;
    e1 = k > 2 ? {tl, gn} : 0;
    e2 = k > 2 ? {al, ex} : 0;
    wv(2 * D, on);
    if (on)
    begin
      if (c0 < 0)
      begin
        c0 = ce;
        ts0 = nts;
      end
      chk(n, D);
      chk(nk, k);
      chk(ni, `CEN_ID_BASE + k);
      chk({ntl, ngn}, e1);
      chk({nal, nex}, e2);
      chk(nts - ts0, ce - c0);
      @(posedge clk);
      #1;
      chk(hk, k);
    end
    else
      chk(n, 2 * D);
  endtask
  task pulse_done;
    @(posedge clk);
    done <= 1;
    @(posedge clk);
    done <= 0;
  endtask
  // Main sequence: reset state, enables, each event kind, then corners.
  initial
  begin
    repeat (4) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    #1;
    chk(id, `CEN_ID_BASE);
    for (k = 0; k < 5; k++) cfg(k, 0, 0);
    for (k = 0; k < 5; k++) cfg(k, 1, 1);
    @(posedge clk);
    sel <= 3'h5;
    sw <= 1;
    @(posedge clk);
    sw <= 0;
    @(posedge clk);
    #1;
    chk(ks, 3'h4);
    fire(2, 1);
    chk(tw, 1);
    fire(0, 1);
    fire(1, 1);
    pulse_done;
    fire(1, 1);
    fire(3, 1);
    fire(4, 1);
    fire(2, 1);
    ext <= 1;
    n = 0;
    while (xs !== 1'b1 && n < 10)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(n < 10, 1);
    if (n == 10)
      results;
    wv(2 * D, 1);
    chk(nk, 0);
    ext <= 0;
    pulse_done;
    cfg(1, 0, 1);
    fire(1, 0);
    @(posedge clk);
    tlt <= 1;
    @(posedge clk);
    tlt <= 0;
    repeat (9) @(posedge clk);
    e1 = tsl;
    tlt <= 1;
    @(posedge clk);
    tlt <= 0;
    @(posedge clk);
    #1;
    chk(tsl - e1, 10);
    @(posedge clk);
    tcl <= 1;
    @(posedge clk);
    {tcl, tlt} <= 2'b01;
    @(posedge clk);
    tlt <= 0;
    @(posedge clk);
    #1;
    chk(tsl < 4, 1);
    chk(hc, 8);
    @(posedge clk);
    rst <= 1;
    repeat (2) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    #1;
    chk({ks, ne}, 0);
    results;
  end
endmodule
`default_nettype wire
